// File: hdl/swc_pkg.sv
package swc_pkg;

  // ****************************************************************
  // Register map, byte addresses on the AXI4-Lite port.
  // ****************************************************************
  localparam logic [7:0] ADDR_SELECT = 8'h00;
  localparam logic [7:0] ADDR_COMMAND = 8'h04;
  localparam logic [7:0] ADDR_SP_LOW = 8'h08;
  localparam logic [7:0] ADDR_SP_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_SP_CONST = 8'h10;
  localparam logic [7:0] ADDR_DIR_LOW = 8'h14;
  localparam logic [7:0] ADDR_DIR_HIGH = 8'h18;
  localparam logic [7:0] ADDR_RETAIN = 8'h1c;
  localparam logic [7:0] ADDR_PRESENT = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h2c;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int CMD_COUNT_IN = 0;
  localparam int CMD_CLEAR = 1;
  localparam int CMD_POWER_LOSS = 2;
  localparam int CMD_FAST_DOWN = 3;
  localparam int STAT_CONTACT = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_RETAIN = 2;
  localparam int IRQ_CONTACT = 0;
  localparam int IRQ_WRAP = 1;
  localparam int IRQ_SWEEP = 2;
  localparam int IRQ_W = 3;

  // ****************************************************************
  // Counter bank layout and reset values.
  // ****************************************************************
  localparam int NUM_COUNTERS = 256;
  localparam logic [7:0] LAST_GENERAL = 8'h3f;
  localparam logic [7:0] LAST_UP_ONLY = 8'hc7;
  localparam logic [31:0] MAX_POS = 32'h7fffffff;
  localparam logic [31:0] MAX_NEG = 32'h80000000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EVAL = 4'b0010,
    ST_CONTACT = 4'b0100,
    ST_SWEEP = 4'b1000
  } swc_state_t;

endpackage

// File: hdl/swc_counter_bank.sv
`timescale 1ns/1ps
module swc_counter_bank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  // ****************************************************************
  // Storage and control state.
  // ****************************************************************
  logic [31:0] present_value [swc_pkg::NUM_COUNTERS];
  logic [31:0] setpoint [swc_pkg::NUM_COUNTERS];
  logic [swc_pkg::NUM_COUNTERS-1:0] contact_reg;
  logic [swc_pkg::NUM_COUNTERS-1:0] retain_reg;
  logic [swc_pkg::NUM_COUNTERS-1:0] count_in_reg;
  logic [63:0] direction_reg;
  logic [7:0] select_reg;
  logic [15:0] sp_low_reg;
  logic [swc_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [swc_pkg::IRQ_W-1:0] irq_mask_reg;
  swc_pkg::swc_state_t state_reg;
  logic [7:0] op_idx_reg;
  logic op_clear_reg;
  logic op_edge_reg;
  logic op_down_reg;
  logic op_hit_reg;
  logic sweep_all_reg;
  logic [7:0] sweep_idx_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_go;
  logic [7:0] wr_addr;
  logic wr_any;
  logic [31:0] eval_old;
  logic [31:0] eval_next;
  logic eval_wrap;
  logic contact_next;
  logic contact_event;
  logic wrap_event;
  logic sweep_event;
  logic read_go;
  logic [31:0] read_data;
  logic read_ok;

  // Byte-lane merge for registers that software writes as plain storage.
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        old_v[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return old_v;
  endfunction

  // ****************************************************************
  // AXI4-Lite write channels.
  // ****************************************************************
  // A write commits only while the bank is idle, so commands never overlap an evaluation.
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid && state_reg == swc_pkg::ST_IDLE;
  assign wr_addr = {aw_addr_reg[7:2], 2'b00};
  assign wr_any = |w_strb_reg;

  // Address and data are caught independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_addr_reg <= 8'h00;
      w_data_reg <= swc_pkg::ZERO_WORD;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response; unmapped and read-only addresses answer with an error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= swc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_addr <= swc_pkg::ADDR_RETAIN || wr_addr == swc_pkg::ADDR_IRQ_MASK) ?
                     swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Plain control registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      select_reg <= 8'h00;
      sp_low_reg <= 16'h0000;
      direction_reg <= 64'h0;
      irq_mask_reg <= swc_pkg::IRQ_MASK_RESET;
    end else if (wr_go) begin
      unique case (wr_addr)
        swc_pkg::ADDR_SELECT: select_reg <= w_strb_reg[0] ? w_data_reg[7:0] : select_reg;
        swc_pkg::ADDR_SP_LOW:
          sp_low_reg <= 16'(merge({16'h0, sp_low_reg}, w_data_reg, w_strb_reg));
        swc_pkg::ADDR_DIR_LOW:
          direction_reg[31:0] <= merge(direction_reg[31:0], w_data_reg, w_strb_reg);
        swc_pkg::ADDR_DIR_HIGH:
          direction_reg[63:32] <= merge(direction_reg[63:32], w_data_reg, w_strb_reg);
        swc_pkg::ADDR_IRQ_MASK:
          irq_mask_reg <= w_strb_reg[0] ? w_data_reg[swc_pkg::IRQ_W-1:0] : irq_mask_reg;
        default: ;
      endcase
    end
  end

  // Setpoints: the high half commits the pair, low register as the low 16 bits.
  always_ff @(posedge aclk) begin
    if (wr_go && wr_any && wr_addr == swc_pkg::ADDR_SP_HIGH) begin
      setpoint[select_reg] <= {w_data_reg[15:0], sp_low_reg};
    end else if (wr_go && wr_any && wr_addr == swc_pkg::ADDR_SP_CONST) begin
      setpoint[select_reg] <= merge(setpoint[select_reg], w_data_reg, w_strb_reg);
    end
  end

  // ****************************************************************
  // Count sequencer.
  // ****************************************************************
  // Index class picks the direction source: general bits, fixed up, or the command bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= swc_pkg::ST_SWEEP;
      sweep_all_reg <= 1'b1;
      sweep_idx_reg <= 8'h00;
      op_idx_reg <= 8'h00;
      op_clear_reg <= 1'b0;
      op_edge_reg <= 1'b0;
      op_down_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        swc_pkg::ST_IDLE: begin
          if (wr_go && wr_any && wr_addr == swc_pkg::ADDR_COMMAND) begin
            if (w_data_reg[swc_pkg::CMD_POWER_LOSS]) begin
              state_reg <= swc_pkg::ST_SWEEP;
              sweep_all_reg <= 1'b0;
              sweep_idx_reg <= 8'h00;
            end else begin
              state_reg <= swc_pkg::ST_EVAL;
              op_idx_reg <= select_reg;
              op_clear_reg <= w_data_reg[swc_pkg::CMD_CLEAR];
              op_edge_reg <= w_data_reg[swc_pkg::CMD_COUNT_IN] && !count_in_reg[select_reg];
              if (select_reg <= swc_pkg::LAST_GENERAL) begin
                op_down_reg <= direction_reg[select_reg[5:0]];
              end else if (select_reg <= swc_pkg::LAST_UP_ONLY) begin
                op_down_reg <= 1'b0;
              end else begin
                op_down_reg <= w_data_reg[swc_pkg::CMD_FAST_DOWN];
              end
            end
          end
        end
        swc_pkg::ST_EVAL: state_reg <= swc_pkg::ST_CONTACT;
        swc_pkg::ST_CONTACT: state_reg <= swc_pkg::ST_IDLE;
        swc_pkg::ST_SWEEP: begin
          sweep_idx_reg <= sweep_idx_reg + 8'h01;
          if (sweep_idx_reg == 8'hff) begin
            state_reg <= swc_pkg::ST_IDLE;
            sweep_all_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // Next value: natural 32-bit arithmetic gives the two's-complement wrap for free.
  always_comb begin
    eval_old = present_value[op_idx_reg];
    eval_next = eval_old;
    eval_wrap = 1'b0;
    if (op_clear_reg) begin
      eval_next = swc_pkg::ZERO_WORD;
    end else if (op_edge_reg && op_down_reg) begin
      eval_next = eval_old - 32'h00000001;
      eval_wrap = eval_old == swc_pkg::MAX_NEG;
    end else if (op_edge_reg) begin
      eval_next = eval_old + 32'h00000001;
      eval_wrap = eval_old == swc_pkg::MAX_POS;
    end
  end

  // Present values; power-up reset clears every counter, a power loss only non-retentive ones.
  always_ff @(posedge aclk) begin
    if (state_reg == swc_pkg::ST_EVAL) begin
      present_value[op_idx_reg] <= eval_next;
    end else if (state_reg == swc_pkg::ST_SWEEP && (sweep_all_reg || !retain_reg[sweep_idx_reg])) begin
      present_value[sweep_idx_reg] <= swc_pkg::ZERO_WORD;
    end
  end

  // The match is judged on the value being stored, in the same cycle as the count, and used one cycle later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_hit_reg <= 1'b0;
    end else if (state_reg == swc_pkg::ST_EVAL) begin
      op_hit_reg <= eval_next == setpoint[op_idx_reg];
    end
  end

  // A held contact is the default, so a count without a match leaves it alone.
  always_comb begin
    contact_next = contact_reg[op_idx_reg];
    if (op_clear_reg) begin
      contact_next = 1'b0;
    end else if (op_edge_reg && op_hit_reg) begin
      contact_next = !op_down_reg;
    end
  end

  // Contacts change in the stage after evaluation; a sweep clears every one at power-up, only non-retentive ones on power loss.
  always_ff @(posedge aclk) begin
    if (state_reg == swc_pkg::ST_CONTACT) begin
      contact_reg[op_idx_reg] <= contact_next;
    end else if (state_reg == swc_pkg::ST_SWEEP && (sweep_all_reg || !retain_reg[sweep_idx_reg])) begin
      contact_reg[sweep_idx_reg] <= 1'b0;
    end
  end

  // Count input levels, so a held level counts once per rising edge.
  always_ff @(posedge aclk) begin
    if (state_reg == swc_pkg::ST_IDLE && wr_go && wr_any && wr_addr == swc_pkg::ADDR_COMMAND &&
        !w_data_reg[swc_pkg::CMD_POWER_LOSS]) begin
      count_in_reg[select_reg] <= w_data_reg[swc_pkg::CMD_COUNT_IN];
    end else if (state_reg == swc_pkg::ST_SWEEP && sweep_all_reg) begin
      count_in_reg[sweep_idx_reg] <= 1'b0;
    end
  end

  // Retention choice per counter; cleared to non-retentive only at power-up reset.
  always_ff @(posedge aclk) begin
    if (wr_go && w_strb_reg[0] && wr_addr == swc_pkg::ADDR_RETAIN) begin
      retain_reg[select_reg] <= w_data_reg[0];
    end else if (state_reg == swc_pkg::ST_SWEEP && sweep_all_reg) begin
      retain_reg[sweep_idx_reg] <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupts and read channel.
  // ****************************************************************
  assign contact_event = state_reg == swc_pkg::ST_CONTACT && contact_next != contact_reg[op_idx_reg];
  assign wrap_event = state_reg == swc_pkg::ST_EVAL && eval_wrap;
  assign sweep_event = state_reg == swc_pkg::ST_SWEEP && sweep_idx_reg == 8'hff;
  assign read_go = s_axi_arvalid && s_axi_arready;

  // Reading the status clears it, but an event in the same cycle is kept.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= '0;
    end else begin
      if (read_go && {s_axi_araddr[7:2], 2'b00} == swc_pkg::ADDR_IRQ_STAT) begin
        irq_stat_reg <= {sweep_event, wrap_event, contact_event};
      end else begin
        irq_stat_reg <= irq_stat_reg | {sweep_event, wrap_event, contact_event};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read decode; an unmapped word answers zero with an error response.
  always_comb begin
    read_data = swc_pkg::ZERO_WORD;
    read_ok = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      swc_pkg::ADDR_SELECT: read_data = {24'h0, select_reg};
      swc_pkg::ADDR_SP_LOW: read_data = {16'h0, setpoint[select_reg][15:0]};
      swc_pkg::ADDR_SP_HIGH: read_data = {16'h0, setpoint[select_reg][31:16]};
      swc_pkg::ADDR_SP_CONST: read_data = setpoint[select_reg];
      swc_pkg::ADDR_DIR_LOW: read_data = direction_reg[31:0];
      swc_pkg::ADDR_DIR_HIGH: read_data = direction_reg[63:32];
      swc_pkg::ADDR_RETAIN: read_data = {31'h0, retain_reg[select_reg]};
      swc_pkg::ADDR_PRESENT: read_data = present_value[select_reg];
      swc_pkg::ADDR_STATUS: read_data = {29'h0, retain_reg[select_reg],
                                         state_reg != swc_pkg::ST_IDLE, contact_reg[select_reg]};
      swc_pkg::ADDR_IRQ_STAT: read_data = {29'h0, irq_stat_reg};
      swc_pkg::ADDR_IRQ_MASK: read_data = {29'h0, irq_mask_reg};
      default: read_ok = 1'b0;
    endcase
  end

  // One read at a time; data is captured at the address handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= swc_pkg::ZERO_WORD;
      s_axi_rresp <= swc_pkg::RESP_OKAY;
    end else if (read_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_data;
      s_axi_rresp <= read_ok ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// File: tb/swc_counter_bank_properties.sv
`timescale 1ns/1ps
module swc_counter_bank_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  // ****************************************************************
  // Bus and interrupt properties.
  // ****************************************************************
  // All checks share the one clock; reset masks them, except the reset check itself.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_idle:
    assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq
      && s_axi_awready && s_axi_wready && s_axi_arready) else $error("Outputs not idle in reset.");
  chk_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped before taken.");
  chk_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp)) else $error("Read data changed before taken.");
  chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read answer not one cycle after address.");
  chk_read_busy:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("Read address accepted early.");
  chk_aw_taken:
    assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("Write address slot not closed.");
  chk_w_taken:
    assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
      else $error("Write data slot not closed.");
  chk_write_answer:
    assert property (s_axi_awvalid && s_axi_awready |-> ##[1:400] s_axi_bvalid)
      else $error("Write response never came.");
  chk_unmapped_read:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h30 |=>
      s_axi_rresp == swc_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
      else $error("Unmapped read not refused.");

  // Main traffic kinds are seen at least once.
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
  cov_irq: cover property ($rose(irq));
endmodule

bind swc_counter_bank swc_counter_bank_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

// File: tb/test_swc_counter_bank.sv
`timescale 1ns/1ps
module test_swc_counter_bank;
  // ****************************************************************
  // Stimulus signals and the unit.
  // ****************************************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdv;
  int fails = 0;
  int samples_checked = 0;

  // Free-running 40 MHz clock.
  always #12.5 aclk = ~aclk;

  swc_counter_bank uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq));

  // ****************************************************************
  // Bus tasks and comparison.
  // ****************************************************************
  task automatic conclude;
    $display("Counts: fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Ready is raised late on purpose so the slave must hold its answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b0;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    rsp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b0;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask

  // One count edge: level high then low, then let the two busy cycles pass.
  task automatic pulse(input logic dn);
    wr(swc_pkg::ADDR_COMMAND, {28'h0, dn, 3'b001});
    wr(swc_pkg::ADDR_COMMAND, {28'h0, dn, 3'b000});
    repeat (3) @(posedge aclk);
  endtask

  task automatic sel(input logic [7:0] i);
    wr(swc_pkg::ADDR_SELECT, {24'h0, i});
  endtask

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(swc_pkg::ADDR_IRQ_MASK, 32'h5);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rc(swc_pkg::ADDR_IRQ_STAT, 32'h4);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    sel(8'h00);
    wr(swc_pkg::ADDR_DIR_LOW, 32'h0);
    wr(swc_pkg::ADDR_SP_LOW, 32'h2);
    wr(swc_pkg::ADDR_SP_HIGH, 32'h0);
    rc(swc_pkg::ADDR_SP_LOW, 32'h2);
    pulse(1'b0);
    rc(swc_pkg::ADDR_STATUS, 32'h0);
    pulse(1'b0);
    rc(swc_pkg::ADDR_PRESENT, 32'h2);
    rc(swc_pkg::ADDR_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rc(swc_pkg::ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    pulse(1'b0);
    rc(swc_pkg::ADDR_PRESENT, 32'h3);
    rc(swc_pkg::ADDR_STATUS, 32'h1);
    wr(swc_pkg::ADDR_DIR_LOW, 32'h1);
    pulse(1'b0);
    rc(swc_pkg::ADDR_STATUS, 32'h0);
    repeat (3) pulse(1'b0);
    rc(swc_pkg::ADDR_PRESENT, 32'hffffffff);
    // A negative setpoint built from two halves, sign in the high half.
    wr(swc_pkg::ADDR_SP_LOW, 32'hfffe);
    wr(swc_pkg::ADDR_SP_HIGH, 32'hffff);
    rc(swc_pkg::ADDR_SP_HIGH, 32'hffff);
    rc(swc_pkg::ADDR_SP_CONST, 32'hfffffffe);
    repeat (2) pulse(1'b0);
    rc(swc_pkg::ADDR_PRESENT, 32'hfffffffd);
    wr(swc_pkg::ADDR_DIR_LOW, 32'h0);
    pulse(1'b0);
    rc(swc_pkg::ADDR_STATUS, 32'h1);
    wr(swc_pkg::ADDR_COMMAND, 32'h3);
    wr(swc_pkg::ADDR_COMMAND, 32'h0);
    repeat (3) @(posedge aclk);
    rc(swc_pkg::ADDR_PRESENT, 32'h0);
    rc(swc_pkg::ADDR_STATUS, 32'h0);
    // A setpoint written whole, as a constant.
    wr(swc_pkg::ADDR_SP_CONST, 32'h00000001);
    rc(swc_pkg::ADDR_SP_HIGH, 32'h0);
    pulse(1'b0);
    rc(swc_pkg::ADDR_STATUS, 32'h1);
    // One counter from each zone of the bank.
    wr(swc_pkg::ADDR_DIR_HIGH, 32'h1);
    sel(8'h20);
    pulse(1'b0);
    rc(swc_pkg::ADDR_PRESENT, 32'hffffffff);
    sel(8'h64);
    pulse(1'b1);
    rc(swc_pkg::ADDR_PRESENT, 32'h1);
    sel(8'hc8);
    pulse(1'b1);
    rc(swc_pkg::ADDR_PRESENT, 32'hffffffff);
    sel(8'h64);
    wr(swc_pkg::ADDR_RETAIN, 32'h1);
    rc(swc_pkg::ADDR_STATUS, 32'h4);
    wr(swc_pkg::ADDR_COMMAND, 32'h4);
    repeat (300) @(posedge aclk);
    rc(swc_pkg::ADDR_PRESENT, 32'h1);
    pulse(1'b0);
    rc(swc_pkg::ADDR_PRESENT, 32'h2);
    sel(8'hc8);
    rc(swc_pkg::ADDR_PRESENT, 32'h0);
    // Refused accesses.
    wr(8'h40, 32'h1);
    chk({30'h0, rsp}, {30'h0, swc_pkg::RESP_SLVERR});
    wr(swc_pkg::ADDR_PRESENT, 32'h5);
    chk({30'h0, rsp}, {30'h0, swc_pkg::RESP_SLVERR});
    rc(swc_pkg::ADDR_PRESENT, 32'h0);
    rc(8'h40, 32'h0);
    chk({30'h0, rsp}, {30'h0, swc_pkg::RESP_SLVERR});
    conclude;
  end

  // Watchdog: the sequence needs a few thousand cycles at most.
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    conclude;
  end
endmodule
